/* bench/tb.sv */
// Self-checking bench of the wake filter, with a frame-sending station.
// Assumes a 20 MHz clock and the register offsets of the package.
`timescale 1ns/10ps
module tb;
  localparam logic [47:0] BC = 48'hffffffffffff;
  logic        ref_clk_i;
  logic        resetn_i;
  logic        ce_i;
  logic        wr_i;
  logic        rd_i;
  logic        wake_o;
  logic        rx_dv_i;
  logic [7:0]  rx_byte_i;
  logic [15:0] addr_i;
  logic [15:0] wdata_i;
  logic [15:0] rdata_o;
  logic [47:0] dm;
  logic [47:0] pw;
  int          n_fail;
  int          num_checks;
  int          cyc = 0;
  int          seed;

  wol_filter_top wol_filter_top_i (.ref_clk_i, .resetn_i, .ce_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_dv_i, .rx_byte_i,
    .wake_o);
  wol_station wol_station_i (.clk_i(ref_clk_i), .dv_o(rx_dv_i),
    .byte_o(rx_byte_i));

  // ==========================================================
  // Clock, hang guard and shared tasks.
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Cuts a hang short once the run passes its expected length.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 check(rdata_o, exp);
  endtask : rd

  task automatic put(input logic [47:0] v);
    for (int k = 0; k < 6; k++) wol_station_i.body_q.push_back(v[k*8 +: 8]);
  endtask : put

  // Adds a zero source address and random payload, then sends.
  task automatic go(input logic [7:0] sfd, input bit bad);
    put(48'h000000000000);
    repeat (50) wol_station_i.body_q.push_back(8'($random(seed)));
    wol_station_i.send(sfd, bad);
  endtask : go

  // Model result of a frame: wake cycles seen, then status read twice.
  task automatic expect_frame(input logic [15:0] sts, input int wl);
    int n;
    n = 0;
    repeat (80) begin
      @(posedge ref_clk_i);
      #1 n += (wake_o === 1'b1) ? 1 : 0;
    end
    check(16'(n), 16'(wl));
    rd(16'h0135, sts);
    rd(16'h0135, 16'h0000);
  endtask : expect_frame

  // ==========================================================
  // Main sequence.
  initial begin
    seed = 32'hf96c;
    resetn_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 16'h0000;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(16'h0134, 16'h0004);
    rd(16'h0135, 16'h0000);
    rd(16'h0150, 16'h0000);
    dm = 48'({$random(seed), $random(seed)});
    dm[0] = 1'b0;
    for (int k = 0; k < 3; k++) rd(16'h0136 + 16'(k), 16'h0000);
    for (int k = 0; k < 3; k++) wr(16'h0136 + 16'(k), dm[k*16 +: 16]);
    for (int k = 0; k < 3; k++)
      rd(16'h0136 + 16'(k), dm[k*16 +: 16]);
    put(BC);
    go(8'h5d, 1'b0);
    expect_frame(16'h0000, 0);
    for (int s = 0; s < 4; s++) begin
      wr(16'h0134, 16'h0084 | 16'(s << 9));
      put(BC);
      go(8'h5d, 1'b0);
      expect_frame(16'h0004, 8 << s);
    end
    wr(16'h0134, 16'h0190);
    put(dm);
    go(8'h5d, 1'b0);
    expect_frame(16'h0010, 80);
    // A clear written while the enable is low must be ignored.
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    wr(16'h0134, 16'h0990);
    ce_i <= 1'b1;
    #1 check({15'h0000, wake_o}, 16'h0001);
    wr(16'h0134, 16'h0990);
    @(posedge ref_clk_i);
    #1 check({15'h0000, wake_o}, 16'h0000);
    rd(16'h0134, 16'h0190);
    wr(16'h0134, 16'h0084);
    put(48'h000000000000);
    go(8'h5d, 1'b1);
    expect_frame(16'h0040, 0);
    put(48'h000000000000);
    go(8'h5a, 1'b0);
    expect_frame(16'h0080, 0);
    pw = 48'({$random(seed), $random(seed)});
    for (int k = 0; k < 3; k++) wr(16'h0139 + 16'(k), pw[k*16 +: 16]);
    wr(16'h0134, 16'h00a1);
    // Third frame: password check off, a wrong password still wakes.
    for (int g = 0; g < 3; g++) begin
      if (g == 2) wr(16'h0134, 16'h0081);
      put(dm);
      put(48'h000000000000);
      put(BC);
      repeat (16) put(dm);
      put(pw ^ 48'(g != 1));
      go(8'h5d, 1'b0);
      expect_frame(g ? 16'h0011 : 16'h0030, g ? 8 : 0);
    end
    wr(16'h013c, 16'h00ff);
    wr(16'h0160, 16'hfffe);
    wr(16'h0134, 16'h0082);
    put(BC);
    go(8'h5d, 1'b0);
    expect_frame(16'h0006, 8);
    stop_test();
  end
endmodule : tb

/* bench/wol_station.sv */
// Remote station model: sends framed bytes with preamble and FCS.
// Assumes the filter takes one byte per rising edge of clk_i.
`timescale 1ns/10ps
module wol_station (
  input  wire logic       clk_i,
  output logic            dv_o,
  output logic      [7:0] byte_o
);
  logic [7:0] body_q[$];

  initial begin
    dv_o   = 1'b0;
    byte_o = 8'h00;
  end

  // Sends preamble, delimiter, body and FCS; bad spoils the FCS.
  task automatic send(input logic [7:0] sfd, input bit bad);
    logic [31:0] crc;
    logic [7:0]  f[$];
    crc = 32'hffffffff;
    repeat (7) f.push_back(8'h55);
    f.push_back(sfd);
    foreach (body_q[i]) begin
      crc = crc ^ {24'h000000, body_q[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
      f.push_back(body_q[i]);
    end
    crc = ~crc ^ {31'h00000000, bad};
    for (int k = 0; k < 4; k++) f.push_back(crc[k*8 +: 8]);
    foreach (f[i]) begin
      @(posedge clk_i);
      dv_o   <= 1'b1;
      byte_o <= f[i];
    end
    @(posedge clk_i);
    dv_o   <= 1'b0;
    byte_o <= ~f[f.size()-1]; // A released line keeps no stale byte.
    body_q.delete();
  endtask : send
endmodule : wol_station

/* rtl/wol_crc32.sv */
// Byte-wise CRC-32 over the received frame body, FCS included.
// Assumes bytes arrive one per enabled clock on the same clock.
`timescale 1ns/10ps
module wol_crc32 (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       start_i,
  input  wire logic       byte_vld_i,
  input  wire logic [7:0] byte_i,
  output logic            crc_ok_o
);

  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // One byte of the reflected polynomial division.
  always_comb begin
    crc_nxt = crc_r ^ {24'h000000, byte_i};
    for (int b = 0; b < 8; b++) begin
      crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ wol_pkg::CRC_POLY)
                           : (crc_nxt >> 1);
    end
  end

  // Register restarts at each delimiter; good frames leave the residue.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_r    <= wol_pkg::CRC_INIT;
      crc_ok_o <= 1'b0;
    end else if (ce_i) begin
      if (start_i) begin
        crc_r    <= wol_pkg::CRC_INIT;
        crc_ok_o <= 1'b0;
      end else if (byte_vld_i) begin
        crc_r    <= crc_nxt;
        crc_ok_o <= (crc_nxt == wol_pkg::CRC_RESIDUE);
      end
    end
  end

endmodule : wol_crc32

/* rtl/wol_filter_top.sv */
// Wake-on-LAN receive filter: frame parser, match logic, flag registers.
// Assumes receive bytes come from logic on ref_clk_i, one per enabled
// cycle while rx_dv_i is high, preamble first and FCS last.
//
// Functional notes
// - Writing one to the clear bit drops a level-mode wake; self-clearing.
// - Pulse mode width is 8, 16, 32 or 64 cycles by stretch field.
// - Output-mode bit one selects level mode, zero selects pulse mode.
// - Wake detection, CRC check and flags work only with enhanced enable.
// - Password enable requires the configured password after magic packets.
// - Unicast enable wakes on frames to the destination match address.
// - Broadcast enable wakes on broadcast frames; resets to one.
// - Pattern enable wakes on frames matching the configured byte pattern.
// - Magic enable wakes on magic packets.
// - Delimiter byte other than 0x5D sets the delimiter error flag.
// - A frame failing its CRC sets the bad checksum flag.
// - A magic packet failing the password check sets the attack flag.
// - A valid unicast frame sets the unicast seen flag.
// - A valid broadcast frame sets the broadcast seen flag.
// - A valid frame with the pattern sets the pattern seen flag.
// - A valid magic packet sets the magic seen flag.
// - Destination match is 48 bits in three registers, low first.
// - Wake password is 48 bits in three registers, low first.
// - Pattern stored two bytes per register; each byte maskable.
`timescale 1ns/10ps
module wol_filter_top (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        rx_dv_i,
  input  wire logic [7:0]  rx_byte_i,
  output logic             wake_o
);

  // ===========================================================================
  // Reset release.
  logic rst_s1_r;
  logic rst_n;

  // Two flops release the asynchronous reset in step with the clock.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ===========================================================================
  // Registers.
  logic [15:0] cfg_r;
  logic [15:0] sts_r;
  logic [15:0] sts_set;
  logic [47:0] dm_r;
  localparam int PAT_REGS_L = wol_pkg::PAT_REGS;
  logic [47:0] pw_r;
  logic [15:0] pat_mem [PAT_REGS_L];
  logic [15:0] pmask_r;
  logic        clr_pulse;
  logic        sts_rd;
  logic [15:0] rd_mux;

  assign sts_rd    = rd_i && (addr_i == wol_pkg::OFF_STS);
  // The clear bit is never stored: a write of one is a one-cycle pulse.
  assign clr_pulse = wr_i && (addr_i == wol_pkg::OFF_CFG)
                     && wdata_i[wol_pkg::CFG_CLEAR];

  // Configuration, match address, password and pattern storage.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r   <= wol_pkg::CFG_RESET;
      dm_r    <= 48'h000000000000;
      pw_r    <= 48'h000000000000;
      pmask_r <= wol_pkg::ZERO16;
      for (int i = 0; i < PAT_REGS_L; i++) begin
        pat_mem[i] <= wol_pkg::ZERO16;
      end
    end else if (ce_i && wr_i) begin
      case (addr_i)
        wol_pkg::OFF_CFG:    cfg_r <= wdata_i & wol_pkg::CFG_WMASK;
        wol_pkg::OFF_DM_LO:  dm_r[15:0]  <= wdata_i;
        wol_pkg::OFF_DM_MID: dm_r[31:16] <= wdata_i;
        wol_pkg::OFF_DM_HI:  dm_r[47:32] <= wdata_i;
        wol_pkg::OFF_PW_LO:  pw_r[15:0]  <= wdata_i;
        wol_pkg::OFF_PW_MID: pw_r[31:16] <= wdata_i;
        wol_pkg::OFF_PW_HI:  pw_r[47:32] <= wdata_i;
        wol_pkg::OFF_PMASK:  pmask_r <= wdata_i;
        default: begin
          if (addr_i >= wol_pkg::OFF_PAT &&
              addr_i < wol_pkg::OFF_PAT + 16'(PAT_REGS_L)) begin
            pat_mem[3'(addr_i - wol_pkg::OFF_PAT)] <= wdata_i;
          end
        end
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = wol_pkg::ZERO16;
    case (addr_i)
      wol_pkg::OFF_CFG:    rd_mux = cfg_r;
      wol_pkg::OFF_STS:    rd_mux = sts_r;
      wol_pkg::OFF_DM_LO:  rd_mux = dm_r[15:0];
      wol_pkg::OFF_DM_MID: rd_mux = dm_r[31:16];
      wol_pkg::OFF_DM_HI:  rd_mux = dm_r[47:32];
      wol_pkg::OFF_PW_LO:  rd_mux = pw_r[15:0];
      wol_pkg::OFF_PW_MID: rd_mux = pw_r[31:16];
      wol_pkg::OFF_PW_HI:  rd_mux = pw_r[47:32];
      wol_pkg::OFF_PMASK:  rd_mux = pmask_r;
      default: begin
        if (addr_i >= wol_pkg::OFF_PAT &&
            addr_i < wol_pkg::OFF_PAT + 16'(PAT_REGS_L)) begin
          rd_mux = pat_mem[3'(addr_i - wol_pkg::OFF_PAT)];
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= wol_pkg::ZERO16;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux : wol_pkg::ZERO16;
    end
  end

  // Sticky flags; a new event wins over the clearing read.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sts_r <= wol_pkg::ZERO16;
    end else if (ce_i) begin
      sts_r <= (sts_rd ? wol_pkg::ZERO16 : sts_r) | sts_set;
    end
  end

  // ===========================================================================
  // Frame parser.
  wol_pkg::wol_rx_state_t state_r;
  logic [10:0] idx_r;
  logic        body_byte;
  logic        sfd_seen;
  logic        frame_end;
  logic        crc_ok;
  logic [47:0] da_r;
  logic        pat_ok_r;
  logic        enh;

  assign enh       = cfg_r[wol_pkg::CFG_ENH];
  assign body_byte = (state_r == wol_pkg::RX_BODY) && rx_dv_i;
  assign sfd_seen  = (state_r != wol_pkg::RX_BODY) && rx_dv_i
                     && (rx_byte_i != wol_pkg::PREAMBLE);
  assign frame_end = (state_r == wol_pkg::RX_BODY) && !rx_dv_i;

  // Preamble is skipped; the first other byte is taken as the delimiter.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= wol_pkg::RX_IDLE;
      idx_r   <= 11'h000;
    end else if (ce_i) begin
      case (state_r)
        wol_pkg::RX_IDLE, wol_pkg::RX_PRE: begin
          idx_r <= 11'h000;
          if (sfd_seen) begin
            state_r <= wol_pkg::RX_BODY;
          end else if (rx_dv_i) begin
            state_r <= wol_pkg::RX_PRE;
          end else begin
            state_r <= wol_pkg::RX_IDLE;
          end
        end
        wol_pkg::RX_BODY: begin
          if (!rx_dv_i) begin
            state_r <= wol_pkg::RX_IDLE;
          end else if (idx_r != 11'h7ff) begin
            idx_r <= idx_r + 11'h001;
          end
        end
        default: state_r <= wol_pkg::RX_IDLE;
      endcase
    end
  end

  wol_crc32 u_crc (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n),
    .ce_i       (ce_i),
    .start_i    (sfd_seen),
    .byte_vld_i (body_byte),
    .byte_i     (rx_byte_i),
    .crc_ok_o   (crc_ok)
  );

  // Destination address capture and masked pattern compare.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      da_r     <= 48'h000000000000;
      pat_ok_r <= 1'b0;
    end else if (ce_i) begin
      if (sfd_seen) begin
        pat_ok_r <= 1'b1;
      end else if (body_byte) begin
        if (idx_r < 11'(wol_pkg::ADDR_BYTES)) begin
          da_r[idx_r[2:0]*8 +: 8] <= rx_byte_i;
        end
        if (idx_r < 11'(wol_pkg::PAT_BYTES) && !pmask_r[idx_r[3:0]] &&
            rx_byte_i != pat_mem[idx_r[3:1]][idx_r[0]*8 +: 8]) begin
          pat_ok_r <= 1'b0;
        end
      end
    end
  end

  // ===========================================================================
  // Magic packet search: six sync bytes, sixteen address copies, password.
  logic [2:0] ff_cnt_r;
  logic [2:0] ai_r;
  logic [6:0] mag_cnt_r;
  logic       mag_found_r;
  logic [2:0] pw_idx_r;
  logic       pw_ok_r;
  logic       pw_good;
  logic       addr_hit;

  assign addr_hit = rx_byte_i == wol_pkg::byte_of(dm_r, ai_r);
  assign pw_good  = pw_ok_r && (pw_idx_r == wol_pkg::ADDR_BYTES);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ff_cnt_r    <= 3'h0;
      ai_r        <= 3'h0;
      mag_cnt_r   <= 7'h00;
      mag_found_r <= 1'b0;
      pw_idx_r    <= 3'h0;
      pw_ok_r     <= 1'b0;
    end else if (ce_i) begin
      if (sfd_seen) begin
        ff_cnt_r    <= 3'h0;
        ai_r        <= 3'h0;
        mag_cnt_r   <= 7'h00;
        mag_found_r <= 1'b0;
        pw_idx_r    <= 3'h0;
        pw_ok_r     <= 1'b1;
      end else if (body_byte && mag_found_r) begin
        if (pw_idx_r != wol_pkg::ADDR_BYTES) begin
          pw_idx_r <= pw_idx_r + 3'h1;
          if (rx_byte_i != wol_pkg::byte_of(pw_r, pw_idx_r)) begin
            pw_ok_r <= 1'b0;
          end
        end
      end else if (body_byte) begin
        if (ff_cnt_r == wol_pkg::MAGIC_SYNC && addr_hit) begin
          ai_r      <= (ai_r == wol_pkg::ADDR_BYTES - 3'h1) ? 3'h0
                                                           : ai_r + 3'h1;
          mag_cnt_r <= mag_cnt_r + 7'h01;
          if (mag_cnt_r == wol_pkg::MAGIC_REPS - 7'h01) begin
            mag_found_r <= 1'b1;
          end
        end else begin
          ai_r      <= 3'h0;
          mag_cnt_r <= 7'h00;
          if (rx_byte_i != wol_pkg::ALL_ONES) begin
            ff_cnt_r <= 3'h0;
          end else if (ff_cnt_r != wol_pkg::MAGIC_SYNC) begin
            ff_cnt_r <= ff_cnt_r + 3'h1;
          end
        end
      end
    end
  end

  // ===========================================================================
  // Frame verdicts, flags and wake trigger.
  logic uc_hit;
  logic bc_hit;
  logic pat_hit;
  logic mag_hit;
  logic hack_hit;
  logic wake_trig;
  logic pw_en;

  assign pw_en    = cfg_r[wol_pkg::CFG_PW_EN];
  assign uc_hit   = crc_ok && (da_r == dm_r);
  assign bc_hit   = crc_ok && (da_r == {6{wol_pkg::ALL_ONES}});
  assign pat_hit  = crc_ok && pat_ok_r
                    && (idx_r >= 11'(wol_pkg::PAT_BYTES));
  assign mag_hit  = crc_ok && mag_found_r && (!pw_en || pw_good);
  assign hack_hit = mag_found_r && pw_en && !pw_good;

  // Flags are raised only while the enhanced receive features are on.
  always_comb begin
    sts_set = wol_pkg::ZERO16;
    if (enh && ce_i) begin
      sts_set[wol_pkg::ST_SFD]  = sfd_seen
                                  && rx_byte_i != wol_pkg::SFD_BYTE;
      sts_set[wol_pkg::ST_CRC]  = frame_end && !crc_ok;
      sts_set[wol_pkg::ST_HACK] = frame_end && hack_hit;
      sts_set[wol_pkg::ST_UC]   = frame_end && uc_hit;
      sts_set[wol_pkg::ST_BC]   = frame_end && bc_hit;
      sts_set[wol_pkg::ST_PAT]  = frame_end && pat_hit;
      sts_set[wol_pkg::ST_MAG]  = frame_end && mag_hit;
    end
  end

  // With enhanced enable on, any enabled match at frame end fires the wake output.
  assign wake_trig = enh && frame_end && (
      (cfg_r[wol_pkg::CFG_UC]  && uc_hit)   ||
      (cfg_r[wol_pkg::CFG_BC]  && bc_hit)   ||
      (cfg_r[wol_pkg::CFG_PAT] && pat_hit)  ||
      (cfg_r[wol_pkg::CFG_MAG] && mag_hit));

  wol_wake_out u_wake (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .trig_i      (wake_trig),
    .level_sel_i (cfg_r[wol_pkg::CFG_LEVEL]),
    .len_sel_i   (cfg_r[wol_pkg::CFG_LEN_LSB +: 2]),
    .clear_i     (clr_pulse),
    .wake_o      (wake_o)
  );

  // ===========================================================================
  // Checks.
  a_bcast_reset: assert property (@(posedge ref_clk_i)
    $rose(rst_n) |-> cfg_r[wol_pkg::CFG_BC])
    else $error("broadcast enable not set after reset");

  a_enh_gate: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) !enh |-> !wake_trig && sts_set == wol_pkg::ZERO16)
    else $error("event raised with enhanced receive off");

  a_sfd_flag: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) enh && ce_i && sfd_seen
    && rx_byte_i != wol_pkg::SFD_BYTE |=> sts_r[wol_pkg::ST_SFD])
    else $error("delimiter error not flagged");

  a_crc_flag: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) enh && ce_i && frame_end && !crc_ok
    |=> sts_r[wol_pkg::ST_CRC])
    else $error("bad checksum not flagged");
  a_hack_flag: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) enh && ce_i && frame_end && mag_found_r
    && pw_en && !pw_good |=> sts_r[wol_pkg::ST_HACK] && !sts_r[wol_pkg::ST_MAG])
    else $error("password attack not flagged");

  a_uc_wake: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) enh && ce_i && frame_end && crc_ok
    && da_r == dm_r && cfg_r[wol_pkg::CFG_UC]
    |=> wake_o && sts_r[wol_pkg::ST_UC])
    else $error("unicast match did not wake");
  a_status_rc: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) ce_i && sts_rd && sts_set == wol_pkg::ZERO16
    |=> sts_r == wol_pkg::ZERO16 && rdata_o == $past(sts_r))
    else $error("status read did not return and clear");

  a_magic_flag: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n) enh && ce_i && frame_end && crc_ok && mag_found_r
    && !pw_en |=> sts_r[wol_pkg::ST_MAG])
    else $error("magic packet not flagged");

endmodule : wol_filter_top

/* rtl/wol_pkg.sv */
// Constants, types and shared helpers of the wake-on-LAN receive filter.
// Assumes one receive byte stream and one plain register port per block.
package wol_pkg;

  // ===========================================================================
  // Register map.
  localparam int              DATA_W      = 16;
  localparam int              ADDR_W      = 16;
  localparam logic [15:0]     OFF_CFG     = 16'h0134;
  localparam logic [15:0]     OFF_STS     = 16'h0135;
  localparam logic [15:0]     OFF_DM_LO   = 16'h0136;
  localparam logic [15:0]     OFF_DM_MID  = 16'h0137;
  localparam logic [15:0]     OFF_DM_HI   = 16'h0138;
  localparam logic [15:0]     OFF_PW_LO   = 16'h0139;
  localparam logic [15:0]     OFF_PW_MID  = 16'h013a;
  localparam logic [15:0]     OFF_PW_HI   = 16'h013b;
  localparam logic [15:0]     OFF_PAT     = 16'h013c;
  localparam logic [15:0]     OFF_PMASK   = 16'h0160;
  localparam int              PAT_REGS    = 8;
  localparam int              PAT_BYTES   = 16;

  // ===========================================================================
  // Configuration fields, reset value and writable bits.
  localparam int              CFG_CLEAR   = 11;
  localparam int              CFG_LEN_LSB = 9;
  localparam int              CFG_LEVEL   = 8;
  localparam int              CFG_ENH     = 7;
  localparam int              CFG_PW_EN   = 5;
  localparam int              CFG_UC      = 4;
  localparam int              CFG_BC      = 2;
  localparam int              CFG_PAT     = 1;
  localparam int              CFG_MAG     = 0;
  localparam logic [15:0]     CFG_RESET   = 16'h0004;
  localparam logic [15:0]     CFG_WMASK   = 16'h07b7;
  localparam logic [15:0]     ZERO16      = 16'h0000;

  // ===========================================================================
  // Status flag positions.
  localparam int              ST_SFD      = 7;
  localparam int              ST_CRC      = 6;
  localparam int              ST_HACK     = 5;
  localparam int              ST_UC       = 4;
  localparam int              ST_BC       = 2;
  localparam int              ST_PAT      = 1;
  localparam int              ST_MAG      = 0;

  // ===========================================================================
  // Frame constants and timing counts.
  localparam logic [7:0]      PREAMBLE    = 8'h55;
  localparam logic [7:0]      SFD_BYTE    = 8'h5d;
  localparam logic [7:0]      ALL_ONES    = 8'hff;
  localparam logic [31:0]     CRC_INIT    = 32'hffffffff;
  localparam logic [31:0]     CRC_POLY    = 32'hedb88320;
  localparam logic [31:0]     CRC_RESIDUE = 32'hdebb20e3;
  localparam logic [2:0]      MAGIC_SYNC  = 3'h6;
  localparam logic [6:0]      MAGIC_REPS  = 7'h60;
  localparam logic [2:0]      ADDR_BYTES  = 3'h6;
  localparam logic [6:0]      PULSE_BASE  = 7'h08;

  // Receive framing states, one-hot.
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_PRE  = 3'b010,
    RX_BODY = 3'b100
  } wol_rx_state_t;

  // Picks byte idx of a 48-bit value, byte 0 in the low bits.
  function automatic logic [7:0] byte_of(input logic [47:0] v,
                                         input logic [2:0]  idx);
    byte_of = v[idx*8 +: 8];
  endfunction : byte_of

endpackage : wol_pkg

/* rtl/wol_wake_out.sv */
// Wake output driver: a stretched pulse or a level held until cleared.
// Assumes trigger and clear are one-cycle pulses on the same clock.
`timescale 1ns/10ps
module wol_wake_out (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       trig_i,
  input  wire logic       level_sel_i,
  input  wire logic [1:0] len_sel_i,
  input  wire logic       clear_i,
  output logic            wake_o
);

  logic [6:0] cnt_r;
  logic [6:0] len;
  logic [6:0] hi_cnt_r;

  // Pulse length is 8 cycles doubled per step of the select field.
  assign len = wol_pkg::PULSE_BASE << len_sel_i;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_o <= 1'b0;
      cnt_r  <= 7'h00;
    end else if (ce_i) begin
      if (trig_i) begin
        wake_o <= 1'b1;
        cnt_r  <= len;
      end else if (level_sel_i) begin
        if (clear_i) begin
          wake_o <= 1'b0;
        end
      end else if (wake_o) begin
        cnt_r <= cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          wake_o <= 1'b0;
        end
      end
    end
  end

  // Counts enabled high cycles of the output for the width check.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt_r <= 7'h00;
    end else if (ce_i) begin
      hi_cnt_r <= (wake_o && !trig_i) ? hi_cnt_r + 7'h01 : 7'h00;
    end
  end

  a_level_clear: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && level_sel_i && clear_i && !trig_i |=> !wake_o)
    else $error("level wake output not cleared");

  a_pulse_width: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ce_i && !level_sel_i && !trig_i && wake_o && cnt_r == 7'h01
    |-> hi_cnt_r + 7'h01 == (wol_pkg::PULSE_BASE << len_sel_i))
    else $error("wake pulse width wrong");

endmodule : wol_wake_out
